// >>> design/qdsl_pkg.sv
// Purpose: shared constants and types for the quad converter serial load link
// Assumes: one system clock at 40 MHz; all link pins sampled into that domain
// Notes: host end makes the serial clock by a divider; device end samples it
// How it works
// RL1 - word is select, two spare, twelve-bit code
// RL2 - first two bits select channel, upper first
// RL3 - bits three, four ignored; code MSB first
// RL4 - strobe low: addressed channel follows shift code
// RL5 - strobe high: all channels hold
// RL6 - reset low forces all channels, no clock
// RL7 - reset code 000 or 800 by select
// RL8 - latched channels keep reset code after release
// RL9 - reset leaves shift register unchanged
// RL10 - shift clock is select OR serial clock
// RL11 - select rising with clock low shifts once
// RL12 - host raises select only while clock high
// RL13 - host holds select high around strobe, reset
// RL14 - shifting under low strobe updates addressed channel
// RL15 - code is straight binary, N/4096 of span
// RL16 - shift register holds last sixteen bits
// RL17 - no OR rising edge, no shift
package qdsl_pkg;
    localparam int         WORD_BITS   = 16;
    localparam int         CODE_BITS   = 12;
    localparam int         SEL_BITS    = 2;
    localparam int         NUM_CHAN    = 4;
    localparam int         SEL_HI_POS  = 15;
    localparam int         SEL_LO_POS  = 14;
    localparam int         CODE_MSB    = 11;
    localparam int         CNT_BITS    = 5;
    localparam logic [CODE_BITS-1:0] CODE_ZERO = 12'h000;
    localparam logic [CODE_BITS-1:0] CODE_MID  = 12'h800;
    localparam int         CLK_MHZ     = 40;
    localparam int         CLK_HALF_NS = 100;   // host serial clock half period
    localparam int         HALF_CYC    = (CLK_HALF_NS * CLK_MHZ) / 1000;
    localparam int         DIV_BITS    = 8;
    localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0F;
endpackage

// >>> design/qdsl_link_if.sv
// Purpose: link wires between host controller and converter front end
// Assumes: all signals plain levels; no two-way pins on this link
// Notes: no clocking block; each end samples as it needs
`timescale 1ns/10ps
interface qdsl_link_if;
    logic serial_in;
    logic serial_clk;
    logic chip_sel_n;
    logic load_strobe_n;
    logic reset_n;
    logic reset_code_select;
    modport host (output serial_in, serial_clk, chip_sel_n, load_strobe_n,
                  reset_n, reset_code_select);
    modport dev  (input serial_in, serial_clk, chip_sel_n, load_strobe_n,
                  reset_n, reset_code_select);
endinterface

// >>> design/qdsl_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input from outside clk_sys domain
// Notes: first stage feeds only the second; output moves when stages 2 and 3 agree
`timescale 1ns/10ps
module qdsl_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } qdsl_sync_t;
    qdsl_sync_t st_q;
    qdsl_sync_t st_d;

    // shift chain, accept a new level when last two stages agree
    always_comb begin
        st_d     = st_q;
        st_d.s1  = pin;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    // hold the idle-high value during reset so no false edge follows release
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
endmodule

// >>> design/qdsl_device.sv
// Purpose: converter front end: shift register, four channel registers
// Assumes: link pins sampled on clk_sys; link reset_n acts without clk edge in output
// Notes: channel outputs are straight binary codes for the analog stage
`timescale 1ns/10ps
module qdsl_device (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    qdsl_link_if.dev                                  link,
    output logic [qdsl_pkg::CODE_BITS-1:0]            chan_code [qdsl_pkg::NUM_CHAN],
    output logic [qdsl_pkg::WORD_BITS-1:0]            shift_word
);
    typedef struct packed {
        logic                                          shclk;
        logic [qdsl_pkg::WORD_BITS-1:0]                sreg;
        logic [qdsl_pkg::NUM_CHAN-1:0][qdsl_pkg::CODE_BITS-1:0] chan;
    } qdsl_dev_t;
    qdsl_dev_t st_q;
    qdsl_dev_t st_d;

    logic sdi_s;
    logic clk_s;
    logic cs_s;
    logic ld_s;
    logic rstn_s;
    logic sel_s;
    logic or_clk;
    logic [qdsl_pkg::WORD_BITS-1:0] sreg_nx;
    logic [qdsl_pkg::CODE_BITS-1:0] rcode;
    logic [qdsl_pkg::SEL_BITS-1:0]  addr;

    // channel index from the upper two word bits
    function automatic logic [qdsl_pkg::SEL_BITS-1:0] sel_of(
        input logic [qdsl_pkg::WORD_BITS-1:0] w);
        sel_of = {w[qdsl_pkg::SEL_HI_POS], w[qdsl_pkg::SEL_LO_POS]}; // [RL2]
    endfunction

    qdsl_sync u_sdi (.clk_sys(clk_sys), .rst(rst), .pin(link.serial_in),
                     .level(sdi_s));
    qdsl_sync u_clk (.clk_sys(clk_sys), .rst(rst), .pin(link.serial_clk),
                     .level(clk_s));
    qdsl_sync u_cs  (.clk_sys(clk_sys), .rst(rst), .pin(link.chip_sel_n),
                     .level(cs_s));
    qdsl_sync u_ld  (.clk_sys(clk_sys), .rst(rst), .pin(link.load_strobe_n),
                     .level(ld_s));
    qdsl_sync u_rs  (.clk_sys(clk_sys), .rst(rst), .pin(link.reset_code_select),
                     .level(sel_s));

    // reset pin needs only a clean level; async effect is applied at the output
    qdsl_sync u_rn  (.clk_sys(clk_sys), .rst(rst), .pin(link.reset_n),
                     .level(rstn_s));

    assign or_clk = cs_s | clk_s; // [RL10]
    assign rcode  = sel_s ? qdsl_pkg::CODE_MID : qdsl_pkg::CODE_ZERO; // [RL7]

    // shift on each rising edge of the combined clock; reset does not touch it
    always_comb begin
        st_d       = st_q;
        st_d.shclk = or_clk;
        sreg_nx    = st_q.sreg;
        if (or_clk && !st_q.shclk) begin // [RL11] [RL17]
            sreg_nx = {st_q.sreg[qdsl_pkg::WORD_BITS-2:0], sdi_s}; // [RL16] [RL1] [RL9]
        end
        st_d.sreg = sreg_nx;
        addr      = sel_of(sreg_nx);
        if (!rstn_s) begin
            for (int i = 0; i < qdsl_pkg::NUM_CHAN; i++) begin
                st_d.chan[i] = rcode; // [RL6]
            end
        end else if (!ld_s) begin
            // low twelve bits are the code, spare bits dropped
            st_d.chan[addr] = sreg_nx[qdsl_pkg::CODE_MSB:0]; // [RL3] [RL4] [RL14] [RL15]
        end
        // strobe high: nothing assigned, every channel holds [RL5] [RL8]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '{shclk: 1'b1, sreg: '0, chan: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // raw reset pin overrides outputs immediately, without waiting for a clock;
    // the override stands until the synced reset has loaded the registers, so the
    // release never shows a stale code for a cycle [RL8]
    generate
        for (genvar g = 0; g < qdsl_pkg::NUM_CHAN; g++) begin : g_out
            assign chan_code[g] = (link.reset_n && rstn_s) ? st_q.chan[g] :
                (link.reset_code_select ? qdsl_pkg::CODE_MID : qdsl_pkg::CODE_ZERO); // [RL6]
        end
    endgenerate

    assign shift_word = st_q.sreg;
endmodule

// >>> design/qdsl_host.sv
// Purpose: host end: sends one 16-bit word, then pulses the load strobe
// Assumes: user raises send for one cycle while busy is low
// Notes: serial clock made by divider from clk_sys, half period HALF_CYC cycles
`timescale 1ns/10ps
module qdsl_host (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    qdsl_link_if.host                              link,
    input  wire logic                              send,
    input  wire logic [qdsl_pkg::SEL_BITS-1:0]     chan_sel,
    input  wire logic [qdsl_pkg::CODE_BITS-1:0]    code,
    input  wire logic                              do_reset,
    input  wire logic                              reset_mid,
    output logic                                   busy
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_LOW   = 5'h02,
        S_HIGH  = 5'h04,
        S_LOAD  = 5'h08,
        S_RST   = 5'h10
    } qdsl_hst_state_t;

    typedef struct packed {
        qdsl_hst_state_t                  st;
        logic [qdsl_pkg::WORD_BITS-1:0]   word;
        logic [qdsl_pkg::CNT_BITS-1:0]    bitn;
        logic [qdsl_pkg::DIV_BITS-1:0]    div;
        logic                             sdo;
        logic                             sck;
        logic                             csn;
        logic                             ldn;
        logic                             rstn;
        logic                             rsel;
    } qdsl_hst_t;
    qdsl_hst_t q_q;
    qdsl_hst_t q_d;
    logic tick;

    assign tick = (q_q.div == qdsl_pkg::DIV_BITS'(qdsl_pkg::HALF_CYC - 1));

    // word build, shift out MSB first with select raised only while clock high
    always_comb begin
        q_d = q_q;
        q_d.div = tick ? '0 : q_q.div + 1'b1;
        unique case (q_q.st)
            S_IDLE: begin
                q_d.div = '0;
                if (do_reset) begin
                    q_d.rsel = reset_mid;
                    q_d.st   = S_RST;
                end else if (send) begin
                    q_d.word = {chan_sel, 2'b00, code}; // [RL1] [RL2]
                    q_d.sdo  = chan_sel[1];
                    q_d.bitn = '0;
                    q_d.csn  = 1'b0;
                    q_d.sck  = 1'b0;
                    q_d.st   = S_LOW;
                end
            end
            S_LOW: if (tick) begin
                q_d.sck = 1'b1;
                q_d.st  = S_HIGH;
            end
            S_HIGH: if (tick) begin
                if (q_q.bitn == qdsl_pkg::LAST_BIT) begin
                    q_d.csn = 1'b1; // clock still high here [RL12]
                    q_d.st  = S_LOAD;
                end else begin
                    q_d.word = {q_q.word[qdsl_pkg::WORD_BITS-2:0], 1'b0};
                    q_d.sdo  = q_q.word[qdsl_pkg::WORD_BITS-2];
                    q_d.bitn = q_q.bitn + 1'b1;
                    q_d.sck  = 1'b0;
                    q_d.st   = S_LOW;
                end
            end
            S_LOAD: if (tick) begin
                q_d.ldn = ~q_q.ldn; // strobe low one half period, select high [RL13]
                if (!q_q.ldn) q_d.st = S_IDLE;
            end
            S_RST: if (tick) begin
                q_d.rstn = ~q_q.rstn; // reset pulse with select held high [RL13]
                if (!q_q.rstn) q_d.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q_q <= '{st: S_IDLE, word: '0, bitn: '0, div: '0, sdo: 1'b0, sck: 1'b1,
                     csn: 1'b1, ldn: 1'b1, rstn: 1'b1, rsel: 1'b0};
        end else begin
            q_q <= q_d;
        end
    end

    assign link.serial_in         = q_q.sdo;
    assign link.serial_clk        = q_q.sck;
    assign link.chip_sel_n        = q_q.csn;
    assign link.load_strobe_n     = q_q.ldn;
    assign link.reset_n           = q_q.rstn;
    assign link.reset_code_select = q_q.rsel;
    assign busy = (q_q.st != S_IDLE);
endmodule

// >>> verif/qdsl_link_props.sv
// Purpose: wire checks on the link between host and device ends
// Assumes: clk_sys samples every link pin; rst synchronous, active high
// Notes: sees only the interface signals, instantiated beside the link
`timescale 1ns/10ps
module qdsl_link_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic serial_in,
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic load_strobe_n,
    input wire logic reset_n,
    input wire logic reset_code_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       sck_q;
    logic [4:0] edges_q;
    // count rising serial clock edges inside a frame
    always_ff @(posedge clk_sys) begin
        sck_q <= serial_clk;
        if (rst || chip_sel_n) edges_q <= 5'h00;
        else if (serial_clk && !sck_q) edges_q <= edges_q + 5'h01;
    end
    // strobe pulse steps: low four cycles, then high
    sequence lo_s;
        !load_strobe_n [*4];
    endsequence
    sequence hi_s;
        load_strobe_n;
    endsequence
    // framing, hold and strobe order on the wire
    cs_rise_clk_a: assert property ($rose(chip_sel_n) |-> serial_clk)
        else $error("chip select rose while serial clock low");
    frame_bits_a: assert property ($rose(chip_sel_n) |-> edges_q == 5'h10)
        else $error("frame did not carry sixteen clock edges");
    strobe_cs_a: assert property (!load_strobe_n |-> chip_sel_n)
        else $error("load strobe low during a frame");
    reset_cs_a: assert property (!reset_n |-> chip_sel_n)
        else $error("reset low during a frame");
    data_hold_a: assert property (!chip_sel_n && serial_clk |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    clk_high_a: assert property ($rose(serial_clk) && !chip_sel_n |-> serial_clk [*4])
        else $error("serial clock high phase too short");
    strobe_len_a: assert property ($fell(load_strobe_n) |-> lo_s ##1 hi_s)
        else $error("load strobe pulse not four cycles");
    reset_sel_a: assert property (!reset_n ##1 !reset_n |-> $stable(reset_code_select))
        else $error("reset code select moved during reset");
endmodule

// >>> verif/tb_top.sv
// Purpose: bench joining host and device ends, plus a hand-driven device
// Assumes: clk_sys 40 MHz; device pins settle through its synchronisers
// Notes: second link is driven by the bench to break host rules on purpose
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        send = 1'b0;
    logic        do_reset = 1'b0;
    logic        reset_mid = 1'b0;
    logic        busy;
    logic [1:0]  chan_sel = 2'h0;
    logic [11:0] code = 12'h000;
    logic [11:0] chan_code [4];
    logic [11:0] chan_code_x [4];
    logic [11:0] exp_code [4];
    logic [15:0] shift_word;
    logic [15:0] shift_word_x;
    logic [15:0] exp_word;
    logic [31:0] seed = 32'h13;
    int          num_errors = 0;
    int          checks_done = 0;
    qdsl_link_if link ();
    qdsl_link_if link_x ();
    // system clock, 25 ns
    always #12.5 clk_sys = ~clk_sys;
    // both ends, a spare device and the wire checker
    qdsl_host qdsl_host_i (.clk_sys(clk_sys), .rst(rst), .link(link.host), .send(send),
        .chan_sel(chan_sel), .code(code), .do_reset(do_reset), .reset_mid(reset_mid),
        .busy(busy));
    qdsl_device qdsl_device_i (.clk_sys(clk_sys), .rst(rst), .link(link.dev),
        .chan_code(chan_code), .shift_word(shift_word));
    qdsl_device qdsl_device_x_i (.clk_sys(clk_sys), .rst(rst), .link(link_x.dev),
        .chan_code(chan_code_x), .shift_word(shift_word_x));
    qdsl_link_props qdsl_link_props_i (.clk_sys(clk_sys), .rst(rst),
        .serial_in(link.serial_in), .serial_clk(link.serial_clk),
        .chip_sel_n(link.chip_sel_n), .load_strobe_n(link.load_strobe_n),
        .reset_n(link.reset_n), .reset_code_select(link.reset_code_select));
    // xorshift source and expected word
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] frame(input logic [1:0] s, input logic [11:0] c);
        return {s, 2'h0, c};
    endfunction
    // verdict and comparison
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic check_chans();
        for (int i = 0; i < 4; i++) check(16'(chan_code[i]), 16'(exp_code[i]));
    endtask
    // bounded wait for host idle, then synchroniser latency
    task automatic wait_idle();
        int n;
        repeat (2) @(posedge clk_sys);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk_sys);
        if (n == 400) begin
            num_errors++;
            conclude();
        end
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic put(input logic [1:0] s, input logic [11:0] c);
        send <= 1'b1;
        chan_sel <= s;
        code <= c;
        @(posedge clk_sys);
        send <= 1'b0;
        wait_idle();
        exp_code[s] = c;
        exp_word = frame(s, c);
        check(shift_word, exp_word);
        check_chans();
    endtask
    task automatic pulse_reset(input logic mid);
        int n;
        do_reset <= 1'b1;
        reset_mid <= mid;
        @(posedge clk_sys);
        do_reset <= 1'b0;
        for (n = 0; n < 20 && link.reset_n !== 1'b0; n++) @(posedge clk_sys);
        if (n == 20) begin
            num_errors++;
            conclude();
        end
        for (int i = 0; i < 4; i++) exp_code[i] = mid ? 12'h800 : 12'h000;
        #1;
        check_chans();
        // look just after the edge that releases the pin, before the synced reset ends
        for (n = 0; n < 20 && link.reset_n !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (n == 20) begin
            num_errors++;
            conclude();
        end
        check_chans();
        wait_idle();
        check_chans();
        check(shift_word, exp_word);
    endtask
    // one shift edge on the spare link by its serial clock
    task automatic clk_bit(input logic d);
        link_x.serial_in <= d;
        link_x.serial_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        link_x.serial_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    // main sequence
    initial begin
        logic [15:0] w;
        {link_x.serial_in, link_x.serial_clk, link_x.chip_sel_n, link_x.load_strobe_n,
            link_x.reset_n, link_x.reset_code_select} <= 6'h1E;
        exp_code = '{default: 12'h000};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int s = 0; s < 4; s++) put(2'(s), 12'hFFF - 12'(s));
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            put(seed[13:12], seed[11:0]);
        end
        pulse_reset(1'b1);
        pulse_reset(1'b0);
        put(2'h1, 12'h800);
        w = seed[31:16];
        link_x.chip_sel_n <= 1'b0;
        for (int b = 15; b >= 0; b--) clk_bit(w[b]);
        repeat (4) @(posedge clk_sys);
        check(shift_word_x, w);
        link_x.load_strobe_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check(16'(chan_code_x[w[15:14]]), 16'(w[11:0]));
        link_x.serial_clk <= 1'b0;
        link_x.serial_in <= ~w[0];
        repeat (4) @(posedge clk_sys);
        link_x.chip_sel_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        w = {w[14:0], ~w[0]};
        check(shift_word_x, w);
        check(16'(chan_code_x[w[15:14]]), 16'(w[11:0]));
        link_x.load_strobe_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        link_x.chip_sel_n <= 1'b0;
        clk_bit(~w[11]);
        repeat (8) @(posedge clk_sys);
        check(16'(chan_code_x[w[15:14]]), 16'(w[11:0]));
        check(shift_word_x, {w[14:0], ~w[11]});
        // select raised with the clock high, then a clock pulse that must not shift
        link_x.chip_sel_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        clk_bit(1'b0);
        repeat (8) @(posedge clk_sys);
        check(shift_word_x, {w[14:0], ~w[11]});
        conclude();
    end
endmodule
